// >>> hw/pic_regs.vh
`ifndef PIC_REGS_VH
`define PIC_REGS_VH

// --------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------
`define PIC_IDX_EN_HIGH 8'h2C
`define PIC_IDX_EN_LOW 8'h3A
`define PIC_IDX_EN_MID 8'h3B
`define PIC_IDX_PEND_HIGH 8'h2E
`define PIC_IDX_PEND_LOW 8'h3C
`define PIC_IDX_PEND_MID 8'h3D
`define PIC_IDX_ACT_CTRL 8'h40

// --------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------
`define PIC_IMF_BIT 0
`define PIC_ACT_TRAP_BIT 0
`define PIC_ACT_WD_BIT 1
`define PIC_ACT_EXT0_BIT 2
`define PIC_ACT_RESET 3'h3
`define PIC_EN_RESET 20'h00000
`define PIC_PEND_RESET 22'h000000
`define PIC_BYTE_ZERO 8'h00

// --------------------------------------------------------------------
// source numbering
// --------------------------------------------------------------------
`define PIC_SRC_SWTRAP 5'h01
`define PIC_SRC_FTRAP 5'h02
`define PIC_SRC_WD 5'h03
`define PIC_SRC_EXT0 5'h04
`define PIC_SRC_FIRST_HIGH 5'h10
`define PIC_SRC_LAST 5'h17

// --------------------------------------------------------------------
// vectors
// --------------------------------------------------------------------
`define PIC_VEC_RESET 16'hFFFE
`define PIC_VEC_SWTRAP 16'hFFFC
`define PIC_VEC_FTRAP 16'hFFFA
`define PIC_VEC_WD 16'hFFF8
`define PIC_VEC_LOW_BASE 16'hFFF6
`define PIC_VEC_HIGH_BASE 16'hFFBE

// --------------------------------------------------------------------
// acceptance timing
// --------------------------------------------------------------------
`define PIC_CLK_PER_MCYC 2'h3
`define PIC_ACCEPT_MCYC 3'h7
`define PIC_PUSH_FIRST 3'h5
`define PIC_SP_DEC 2'h3

`endif

// >>> hw/pic_ctrl.v
// What this block does
// - 24 sources; four internal ones non-maskable
// - request sets pending latch until accepted/cleared
// - maskable needs global and own enable
// - fixed priority, lower latch number first
// - non-maskables at level two, below reset; software/illegal trap, then fetch trap, then watchdog
// - each source has its own vector, except software and illegal traps, which share FFFC
// - software and illegal traps: no latch, FFFC
// - external pin 0 also needs pin enable
// - fetch trap interrupts only when select cleared
// - watchdog interrupts only when select cleared
// - accepted source latch cleared immediately
// - all pending latches zero after reset
// - pending latches readable at three addresses
// - write zero clears latch, one keeps
// - non-maskables ignore all enable bits
// - enable register readable, writable at three addresses
// - global enable bit0 low, reset/maskable accept clear
// - acceptance takes eight machine cycles
// - push status, high, low; stack minus three
//
// Added by the designer: register access over Avalon-MM and the address map.
`include "pic_regs.vh"

module pic_ctrl (
  // clock and reset
  input wire clk,
  input wire srst,
  // avalon-mm slave
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // request sources
  input wire sw_trap_irq,
  input wire illegal_op_irq,
  input wire fetch_trap_irq,
  input wire wd_irq,
  input wire [23:4] src_irq,
  // reset requests when action selects pick reset
  output reg trap_reset_req,
  output reg wd_reset_req,
  // cpu core side
  input wire cpu_accept,
  output reg irq_request,
  output reg irq_nmi,
  output reg [15:0] irq_vector,
  output reg push_strobe,
  output reg [1:0] push_sel,
  output reg stack_imf,
  output reg sp_dec_strobe,
  output reg [1:0] sp_dec_amount,
  output reg vector_load,
  output reg [4:0] accepted_src
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state;
  reg [1:0] div_cnt;
  reg mcyc_en;
  reg [2:0] mcyc_cnt;
  reg [23:2] int_pending_latch;
  reg [23:4] source_irq_enable;
  reg master_irq_enable;
  reg trap_action_select;
  reg wd_action_select;
  reg ext0_pin_enable;
  reg [4:0] run_src;
  reg run_nmi;

  reg [23:2] set_vec;
  reg [23:2] clr_vec;
  reg [23:4] ok_vec;
  reg [4:0] sel_src;
  reg sel_any;
  reg sel_nmi;
  reg [7:0] rd_byte;
  integer i;

  wire [7:0] reg_idx = address[9:2];
  wire bus_req = read | write;
  wire wr_take = write & ~waitrequest & byteenable[0];
  wire acc_take = (state == ST_IDLE) & cpu_accept & sel_any;

  // ------------------------------------------------------------------
  // vector lookup
  // ------------------------------------------------------------------
  function [15:0] vec_of;
    input [4:0] idx;
    begin
      if (idx == `PIC_SRC_SWTRAP) begin
        vec_of = `PIC_VEC_SWTRAP;
      end else if (idx == `PIC_SRC_FTRAP) begin
        vec_of = `PIC_VEC_FTRAP;
      end else if (idx == `PIC_SRC_WD) begin
        vec_of = `PIC_VEC_WD;
      end else if (idx < `PIC_SRC_FIRST_HIGH) begin
        vec_of = `PIC_VEC_LOW_BASE - {10'h000, idx - `PIC_SRC_EXT0, 1'b0};
      end else begin
        vec_of = `PIC_VEC_HIGH_BASE - {10'h000, idx - `PIC_SRC_FIRST_HIGH, 1'b0};
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // latch set/clear terms
  // ------------------------------------------------------------------
  always @* begin
    set_vec = {src_irq, 2'b00};
    set_vec[2] = fetch_trap_irq & ~trap_action_select;
    set_vec[3] = wd_irq & ~wd_action_select;
    clr_vec = 22'h000000;
    if (wr_take) begin
      // only zeros clear; ones leave the latch alone
      if (reg_idx == `PIC_IDX_PEND_LOW) begin
        clr_vec[7:2] = ~writedata[7:2];
      end else if (reg_idx == `PIC_IDX_PEND_MID) begin
        clr_vec[15:8] = ~writedata[7:0];
      end else if (reg_idx == `PIC_IDX_PEND_HIGH) begin
        clr_vec[23:16] = ~writedata[7:0];
      end
    end
    if (acc_take && sel_src != `PIC_SRC_SWTRAP) begin
      clr_vec[sel_src] = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // priority selection
  // ------------------------------------------------------------------
  always @* begin
    ok_vec = int_pending_latch[23:4] & source_irq_enable
             & {20{master_irq_enable}};
    ok_vec[4] = ok_vec[4] & ext0_pin_enable;
    sel_src = `PIC_SRC_SWTRAP;
    sel_any = 1'b0;
    sel_nmi = 1'b0;
    // lowest latch number wins, so scan downward
    for (i = 23; i >= 4; i = i - 1) begin
      if (ok_vec[i]) begin
        sel_src = i[4:0];
        sel_any = 1'b1;
      end
    end
    // non-maskables sit above every maskable; software/illegal trap first, then fetch trap, then watchdog
    if (sw_trap_irq | illegal_op_irq) begin
      sel_src = `PIC_SRC_SWTRAP;
      sel_any = 1'b1;
      sel_nmi = 1'b1;
    end else if (int_pending_latch[2]) begin
      sel_src = `PIC_SRC_FTRAP;
      sel_any = 1'b1;
      sel_nmi = 1'b1;
    end else if (int_pending_latch[3]) begin
      sel_src = `PIC_SRC_WD;
      sel_any = 1'b1;
      sel_nmi = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------------
  always @* begin
    rd_byte = `PIC_BYTE_ZERO;
    if (reg_idx == `PIC_IDX_EN_LOW) begin
      rd_byte = {source_irq_enable[7:4], 3'b000, master_irq_enable};
    end else if (reg_idx == `PIC_IDX_EN_MID) begin
      rd_byte = source_irq_enable[15:8];
    end else if (reg_idx == `PIC_IDX_EN_HIGH) begin
      rd_byte = source_irq_enable[23:16];
    end else if (reg_idx == `PIC_IDX_PEND_LOW) begin
      rd_byte = {int_pending_latch[7:2], 2'b00};
    end else if (reg_idx == `PIC_IDX_PEND_MID) begin
      rd_byte = int_pending_latch[15:8];
    end else if (reg_idx == `PIC_IDX_PEND_HIGH) begin
      rd_byte = int_pending_latch[23:16];
    end else if (reg_idx == `PIC_IDX_ACT_CTRL) begin
      rd_byte = {5'h00, ext0_pin_enable, wd_action_select, trap_action_select};
    end
  end

  // ------------------------------------------------------------------
  // bus slave: one wait cycle, then the answer
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= ~(bus_req & waitrequest);
      if (read & waitrequest) begin
        readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ------------------------------------------------------------------
  // pending latches and enables
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      int_pending_latch <= `PIC_PEND_RESET;
      source_irq_enable <= `PIC_EN_RESET;
      master_irq_enable <= 1'b0;
      {ext0_pin_enable, wd_action_select, trap_action_select} <= `PIC_ACT_RESET;
    end else begin
      // set listed last so a same-cycle request survives a clear
      int_pending_latch <= (int_pending_latch & ~clr_vec) | set_vec;
      if (wr_take) begin
        if (reg_idx == `PIC_IDX_EN_LOW) begin
          source_irq_enable[7:4] <= writedata[7:4];
          master_irq_enable <= writedata[`PIC_IMF_BIT];
        end else if (reg_idx == `PIC_IDX_EN_MID) begin
          source_irq_enable[15:8] <= writedata[7:0];
        end else if (reg_idx == `PIC_IDX_EN_HIGH) begin
          source_irq_enable[23:16] <= writedata[7:0];
        end else if (reg_idx == `PIC_IDX_ACT_CTRL) begin
          trap_action_select <= writedata[`PIC_ACT_TRAP_BIT];
          wd_action_select <= writedata[`PIC_ACT_WD_BIT];
          ext0_pin_enable <= writedata[`PIC_ACT_EXT0_BIT];
        end
      end
      // maskable acceptance overrides a same-cycle software write of the flag
      if (acc_take && !sel_nmi) begin
        master_irq_enable <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // reset requests for trap and watchdog
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      trap_reset_req <= 1'b0;
      wd_reset_req <= 1'b0;
    end else begin
      trap_reset_req <= fetch_trap_irq & trap_action_select;
      wd_reset_req <= wd_irq & wd_action_select;
    end
  end

  // ------------------------------------------------------------------
  // machine-cycle enable (four clocks)
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      div_cnt <= 2'h0;
      mcyc_en <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      mcyc_en <= (div_cnt == `PIC_CLK_PER_MCYC);
    end
  end

  // ------------------------------------------------------------------
  // acceptance sequence
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      mcyc_cnt <= 3'h0;
      run_src <= `PIC_SRC_SWTRAP;
      run_nmi <= 1'b0;
      irq_request <= 1'b0;
      irq_nmi <= 1'b0;
      irq_vector <= `PIC_VEC_RESET;
      push_strobe <= 1'b0;
      push_sel <= 2'h0;
      stack_imf <= 1'b0;
      sp_dec_strobe <= 1'b0;
      sp_dec_amount <= 2'h0;
      vector_load <= 1'b0;
      accepted_src <= 5'h00;
    end else begin
      push_strobe <= 1'b0;
      sp_dec_strobe <= 1'b0;
      vector_load <= 1'b0;
      case (state)
        ST_IDLE: begin
          irq_request <= sel_any & ~acc_take;
          irq_nmi <= sel_nmi;
          irq_vector <= vec_of(sel_src);
          if (acc_take) begin
            state <= ST_RUN;
            mcyc_cnt <= 3'h0;
            run_src <= sel_src;
            run_nmi <= sel_nmi;
            stack_imf <= master_irq_enable;
            accepted_src <= sel_src;
          end
        end
        ST_RUN: begin
          irq_request <= 1'b0;
          if (mcyc_en) begin
            mcyc_cnt <= mcyc_cnt + 3'h1;
            if (mcyc_cnt >= `PIC_PUSH_FIRST) begin
              // status with flag, then pc high, then pc low
              push_strobe <= 1'b1;
              push_sel <= mcyc_cnt[1:0] - 2'h1;
            end
            if (mcyc_cnt == `PIC_ACCEPT_MCYC) begin
              state <= ST_IDLE;
              vector_load <= 1'b1;
              irq_vector <= vec_of(run_src);
              irq_nmi <= run_nmi;
              sp_dec_strobe <= 1'b1;
              sp_dec_amount <= `PIC_SP_DEC;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> verif/pic_ctrl_monitor.sv
module pic_mon (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // sources and reset requests
  input wire logic fetch_trap_irq,
  input wire logic wd_irq,
  input wire logic trap_reset_req,
  input wire logic wd_reset_req,
  // cpu side
  input wire logic cpu_accept,
  input wire logic irq_request,
  input wire logic irq_nmi,
  input wire logic [15:0] irq_vector,
  input wire logic push_strobe,
  input wire logic [1:0] push_sel,
  input wire logic stack_imf,
  input wire logic sp_dec_strobe,
  input wire logic [1:0] sp_dec_amount,
  input wire logic vector_load,
  input wire logic [4:0] accepted_src
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_reset_quiet: assert property ($fell(srst) |-> !irq_request && !push_strobe)
    else $error("request active right after reset");
  a_accept_time: assert property (cpu_accept && irq_request |=> !irq_request ##[28:32] vector_load)
    else $error("acceptance length wrong");
  a_push_order: assert property (push_strobe && push_sel == 2'h0 |-> ##4 push_strobe && push_sel == 2'h1 ##4 push_strobe && push_sel == 2'h2 && vector_load)
    else $error("push order wrong");
  a_load_stack: assert property (vector_load |-> sp_dec_strobe && sp_dec_amount == 2'h3)
    else $error("stack decrement missing at vector load");
  a_stack_enable: assert property (cpu_accept && irq_request && !irq_nmi |=> stack_imf)
    else $error("stacked global enable wrong");
  a_vector_map: assert property (vector_load |-> irq_vector ==
    ((accepted_src < 5'h10) ? 16'hFFFE : 16'hFFDE) - {10'h000, accepted_src, 1'b0})
    else $error("vector does not match source");
  a_trap_cause: assert property (trap_reset_req |-> $past(fetch_trap_irq))
    else $error("trap reset request without event");
  a_wd_cause: assert property (wd_reset_req |-> $past(wd_irq))
    else $error("watchdog reset request without event");
  cover property (cpu_accept && irq_request && irq_nmi);
  cover property (cpu_accept && irq_request && !irq_nmi);
  cover property (wd_reset_req);
endmodule

bind pic_ctrl pic_mon i_pic_mon (.clk(clk), .srst(srst), .read(read), .write(write),
  .waitrequest(waitrequest), .fetch_trap_irq(fetch_trap_irq), .wd_irq(wd_irq),
  .trap_reset_req(trap_reset_req), .wd_reset_req(wd_reset_req), .cpu_accept(cpu_accept),
  .irq_request(irq_request), .irq_nmi(irq_nmi), .irq_vector(irq_vector),
  .push_strobe(push_strobe), .push_sel(push_sel), .stack_imf(stack_imf),
  .sp_dec_strobe(sp_dec_strobe), .sp_dec_amount(sp_dec_amount), .vector_load(vector_load),
  .accepted_src(accepted_src));

// >>> verif/pic_cpu_model.sv
module pic_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench control: accept only while take is high
  input wire logic take,
  // controller side
  input wire logic irq_request,
  input wire logic vector_load,
  input wire logic [15:0] irq_vector,
  output logic cpu_accept,
  output logic got,
  output logic [15:0] vec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic used;
  // one acceptance per take window, so a slow bench never double-accepts
  always @(posedge clk) begin
    if (srst) begin
      cpu_accept <= 1'b0;
      used <= 1'b0;
      got <= 1'b0;
      vec <= 16'h0000;
    end else begin
      cpu_accept <= take && irq_request && !used && !cpu_accept;
      used <= take && (used || cpu_accept);
      got <= vector_load;
      if (vector_load) vec <= irq_vector;
    end
  end
endmodule

// >>> verif/pic_ctrl_tb_top.sv
module pic_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, read, write, take, got, waitrequest, cpu_accept, irq_request;
  logic trap_reset_req, wd_reset_req, vector_load;
  logic [3:0] be;
  logic [9:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [23:0] ev;
  logic [15:0] irq_vector, vec;
  logic [7:0] ri [8] = '{8'h3A, 8'h3B, 8'h2C, 8'h3C, 8'h3D, 8'h2E, 8'h40, 8'h41};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [15:0] nv [4] = '{16'hFFFC, 16'hFFFC, 16'hFFFA, 16'hFFF8};
  logic [15:0] mv [3] = '{16'hFFF6, 16'hFFF2, 16'hFFF0};
  int bad_count, checked, i, k;

  pic_ctrl i_pic_ctrl (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
    .waitrequest(waitrequest), .sw_trap_irq(ev[1]), .illegal_op_irq(ev[0]),
    .fetch_trap_irq(ev[2]), .wd_irq(ev[3]), .src_irq(ev[23:4]),
    .trap_reset_req(trap_reset_req), .wd_reset_req(wd_reset_req), .cpu_accept(cpu_accept),
    .irq_request(irq_request), .irq_nmi(), .irq_vector(irq_vector), .push_strobe(),
    .push_sel(), .stack_imf(), .sp_dec_strobe(), .sp_dec_amount(),
    .vector_load(vector_load), .accepted_src());
  pic_cpu_model i_pic_cpu_model (.clk(clk), .srst(srst), .take(take),
    .irq_request(irq_request), .vector_load(vector_load), .irq_vector(irq_vector),
    .cpu_accept(cpu_accept), .got(got), .vec(vec));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    address <= {idx, 2'h0};
    read <= !w;
    write <= w;
    writedata <= {24'h000000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task pulse(input logic [23:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 24'h000000;
    @(posedge clk);
  endtask
  // bounded wait for the model to see the vector load
  task acc(input logic [15:0] exp);
    i = 0;
    take <= 1'b1;
    while (got !== 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    // a missed vector load must not pass on a stale vector
    if (i >= 200) bad_count++;
    take <= 1'b0;
    @(posedge clk);
    chk(vec, exp);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report;
  end
  initial begin
    {srst, read, write, take} <= 4'h8;
    be <= 4'h1;
    ev <= 24'h000000;
    address <= 10'h000;
    writedata <= 32'h00000000;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 8; k++) rdchk(ri[k], rv[k]);
    $display("test reset values done");
    bus(1'b1, 8'h3B, 8'hAA);
    rdchk(8'h3B, 8'hAA);
    bus(1'b1, 8'h2C, 8'h55);
    rdchk(8'h2C, 8'h55);
    bus(1'b1, 8'h3A, 8'hFF);
    rdchk(8'h3A, 8'hF1);
    bus(1'b1, 8'h3A, 8'h00);
    bus(1'b1, 8'h41, 8'hFF);
    rdchk(8'h41, 8'h00);
    be <= 4'h0;
    bus(1'b1, 8'h3B, 8'h55);
    be <= 4'h1;
    rdchk(8'h3B, 8'hAA);
    $display("test enables done");
    pulse(24'h000200);
    rdchk(8'h3D, 8'h02);
    chk(irq_request, 1'b0);
    bus(1'b1, 8'h3D, 8'hFF);
    rdchk(8'h3D, 8'h02);
    bus(1'b1, 8'h3D, 8'hFD);
    rdchk(8'h3D, 8'h00);
    bus(1'b1, 8'h3B, 8'h00);
    bus(1'b1, 8'h2C, 8'h00);
    $display("test latches done");
    bus(1'b1, 8'h40, 8'h00);
    pulse(24'h0000F0);
    bus(1'b1, 8'h3A, 8'hF1);
    acc(16'hFFF4);
    rdchk(8'h3A, 8'hF0);
    rdchk(8'h3C, 8'hD0);
    bus(1'b1, 8'h40, 8'h04);
    for (k = 0; k < 3; k++) begin
      bus(1'b1, 8'h3A, 8'hF1);
      acc(mv[k]);
    end
    fork
      bus(1'b1, 8'h3C, 8'h0C);
      begin
        @(posedge clk);
        ev <= 24'h000020;
        @(posedge clk);
        ev <= 24'h000000;
      end
    join
    rdchk(8'h3C, 8'h20);
    bus(1'b1, 8'h3C, 8'h0C);
    rdchk(8'h3C, 8'h00);
    bus(1'b1, 8'h2C, 8'h81);
    pulse(24'h810000);
    rdchk(8'h2E, 8'h81);
    bus(1'b1, 8'h3A, 8'h01);
    acc(16'hFFBE);
    bus(1'b1, 8'h3A, 8'h01);
    acc(16'hFFB0);
    $display("test maskable done");
    for (k = 0; k < 4; k++) begin
      if (k < 2) ev <= 24'h000001 << k;
      else pulse(24'h000001 << k);
      acc(nv[k]);
      ev <= 24'h000000;
      // let the held trap level drop before the next source is raised
      @(posedge clk);
    end
    bus(1'b1, 8'h40, 8'h03);
    pulse(24'h000004);
    chk(trap_reset_req, 1'b1);
    pulse(24'h000008);
    chk(wd_reset_req, 1'b1);
    rdchk(8'h3C, 8'h00);
    $display("test non-maskable done");
    final_report;
  end
endmodule
